//--- verilog/ocd_framer.sv
// Product data and port congestion descriptor framer with register port.
//
// Contract
// R1: product tag 0001 0008h, length 60 bytes.
// R2: vendor name ASCII, words 2-5.
// R3: part number ASCII, words 6-9.
// R4: serial number ASCII, words 10-13.
// R5: revision word; two bytes in 31-16.
// R6: date code ASCII from word 16.
// R7: congestion tag 0001 0009h in word 0.
// R8: congestion length 56 bytes in word 1.
// R9: validity mask in word 2, per counter.
// R10: words 3-15 hold counters in fixed order.
// R11: mask bit 31 marks sampled credit counters.
// R12: bits 12-9 flag vendor counters 4-1.
// R13: bits 8, 7 flag rx, tx link-reset counts.
// R14: bit 6 flags tx discard interval.
// R15: discard count valid needs bits 5 and 6.
// R16: bit 4 flags credit interval.
// R17: zero-credit counts valid need bit 4.
// R18: bits 1, 0 flag rx, tx transitions.
// R19: reserved mask bits 30-13 read zero.
// R20: counters never reset, wrap to zero; here RESET_N clears every counter to zero.
// R21: tx transition count on credit reaching zero.
`timescale 1ns/1ns
`default_nettype none
module ocd_framer
	import ocd_pkg::*;
(
	input  wire logic                  CLK,            // 250 MHz clock.
	input  wire logic                  RESET_N,        // Sync reset, low.
	input  wire logic [ocd_pkg::ADDR_W-1:0] ADDR,      // Byte address.
	input  wire logic [ocd_pkg::DATA_W-1:0] WDATA,     // Write data.
	input  wire logic                  WR,             // Write strobe.
	input  wire logic                  RD,             // Read strobe.
	output logic [ocd_pkg::DATA_W-1:0] RDATA,          // Read data.
	input  wire logic                  TX_CREDIT_ZERO, // Tx credit is 0.
	input  wire logic                  RX_CREDIT_ZERO, // Rx credit is 0.
	input  wire logic                  TX_ZC_HIT,      // Tx zero hit.
	input  wire logic                  RX_ZC_HIT,      // Rx zero hit.
	input  wire logic                  TX_DISCARD,     // Frame dropped.
	input  wire logic                  TX_LR,          // Link reset sent.
	input  wire logic                  RX_LR,          // Link reset seen.
	input  wire logic [3:0]            VENDOR_EVT,     // Vendor events.
	input  wire logic                  DESC_START,     // Start descriptor.
	input  wire ocd_pkg::ocd_sel_t     DESC_SEL,       // Which one.
	input  wire logic                  DESC_READY,     // Sink ready.
	output logic                       DESC_VALID,     // Word valid.
	output logic [ocd_pkg::DATA_W-1:0] DESC_DATA,      // Word data.
	output logic                       DESC_LAST,      // Final word.
	output logic                       DESC_BUSY       // In flight.
);
	////////////////////////////////////////////////////////////////////////
	// Register decode.

	logic [DATA_W-1:0] prod_r [PROD_WORDS];
	logic [DATA_W-1:0] mask_cfg_r;
	logic [DATA_W-1:0] cred_int_r;
	logic [DATA_W-1:0] disc_int_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [DATA_W-1:0] cnt [NUM_CNT];

	wire               prod_hit;
	wire               cnt_hit;
	wire [3:0]         reg_idx;
	wire               wr_mask;
	wire               wr_cred;
	wire               wr_disc;

	assign reg_idx  = ADDR[5:2];
	assign prod_hit = (ADDR >= OFS_PROD) && (ADDR < OFS_PROD_END)
		&& (ADDR[1:0] == 2'h0);
	assign cnt_hit  = (ADDR >= OFS_CNT) && (ADDR < OFS_CNT_END)
		&& (ADDR[1:0] == 2'h0);
	assign wr_mask  = WR && (ADDR == OFS_MASK);
	assign wr_cred  = WR && (ADDR == OFS_CRED_INT);
	assign wr_disc  = WR && (ADDR == OFS_DISC_INT);

	// Product words are written whole; ASCII lands most significant byte
	// first, so the first character of each string sits in bits 31-24.
	generate
		for (genvar i = 0; i < PROD_WORDS; i++) begin : g_prod
			wire wr_this;
			assign wr_this = WR && prod_hit && (reg_idx == 4'(i));
			always_ff @(posedge CLK) begin
				if (!RESET_N) begin
					prod_r[i] <= RST_WORD;
				end else if (wr_this) begin
					prod_r[i] <= WDATA; // R2 R3 R4 R5 R6
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			mask_cfg_r <= RST_WORD;
			cred_int_r <= RST_WORD;
			disc_int_r <= RST_WORD;
		end else begin
			if (wr_mask) begin
				mask_cfg_r <= WDATA & MASK_WMASK; // R19
			end
			if (wr_cred) begin
				cred_int_r <= WDATA;
			end
			if (wr_disc) begin
				disc_int_r <= WDATA;
			end
		end
	end

	// Read data stand only in the cycle after the strobe; otherwise zero.
	always_comb begin
		rdata_nxt = RST_WORD;
		if (RD) begin
			if (prod_hit) begin
				rdata_nxt = prod_r[reg_idx];
			end else if (cnt_hit) begin
				rdata_nxt = cnt[reg_idx];
			end else if (ADDR == OFS_MASK) begin
				rdata_nxt = mask_cfg_r;
			end else if (ADDR == OFS_CRED_INT) begin
				rdata_nxt = cred_int_r;
			end else if (ADDR == OFS_DISC_INT) begin
				rdata_nxt = disc_int_r;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rdata_r <= RST_WORD;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign RDATA = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// Congestion counters.

	logic              tx_zero_d_r;
	logic              rx_zero_d_r;
	wire [NUM_CNT-1:0] evt;

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			tx_zero_d_r <= 1'b0;
			rx_zero_d_r <= 1'b0;
		end else begin
			tx_zero_d_r <= TX_CREDIT_ZERO;
			rx_zero_d_r <= RX_CREDIT_ZERO;
		end
	end

	// A credit already at zero when reset releases is counted as a
	// transition, as the delayed copy resets low; otherwise only a fall from nonzero to zero is.
	assign evt[0]    = TX_CREDIT_ZERO && !tx_zero_d_r; // R21
	assign evt[1]    = RX_CREDIT_ZERO && !rx_zero_d_r;
	assign evt[2]    = TX_ZC_HIT;
	assign evt[3]    = RX_ZC_HIT;
	assign evt[4]    = TX_DISCARD;
	assign evt[5]    = TX_LR;
	assign evt[6]    = RX_LR;
	assign evt[10:7] = VENDOR_EVT;

	generate
		for (genvar c = 0; c < NUM_CNT; c++) begin : g_cnt
			ocd_counter u_cnt (
				.clk   (CLK),
				.rst_n (RESET_N),
				.inc   (evt[c]),
				.count (cnt[c])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Descriptor words.

	wire [DATA_W-1:0] mask_word;
	wire [DATA_W-1:0] cong_w [NUM_CW];

	// Validity bits are passed as software set them; a receiver must
	// itself combine bit 5 with 6 and bits 2, 3 with 4.
	assign mask_word = {mask_cfg_r[MB_SAMPLED], 18'h0_0000, // R11 R19
		mask_cfg_r[12:0]}; // R9 R12 R13 R14 R15 R16 R17 R18

	assign cong_w[0]  = cnt[0]; // R10
	assign cong_w[1]  = cnt[1];
	assign cong_w[2]  = cnt[2];
	assign cong_w[3]  = cnt[3];
	assign cong_w[4]  = cred_int_r;
	assign cong_w[5]  = cnt[4];
	assign cong_w[6]  = disc_int_r;
	assign cong_w[7]  = cnt[5];
	assign cong_w[8]  = cnt[6];
	assign cong_w[9]  = cnt[7];
	assign cong_w[10] = cnt[8];
	assign cong_w[11] = cnt[9];
	assign cong_w[12] = cnt[10];

	////////////////////////////////////////////////////////////////////////
	// Stream sequencing.

	ocd_sel_t         sel_r;
	wire ocd_sel_t    sel_w;
	logic [DATA_W-1:0] data_r;
	logic [DATA_W-1:0] word_w;
	wire              adv;
	wire              busy;
	wire [IDX_W-1:0]  nidx;
	wire [IDX_W-1:0]  cur_idx;
	wire [IDX_W-1:0]  last_idx;
	wire [IDX_W-1:0]  prod_off;
	wire [IDX_W-1:0]  cong_off;

	assign sel_w    = busy ? sel_r : DESC_SEL;
	assign last_idx = (DESC_SEL == OCD_SEL_PROD) ? PROD_LAST : CONG_LAST;
	assign prod_off = nidx - PW_VNAME;
	assign cong_off = nidx - CW_FIRST;

	always_comb begin
		word_w = RST_WORD;
		if (sel_w == OCD_SEL_PROD) begin
			if (nidx == W_TAG) begin
				word_w = PROD_TAG; // R1
			end else if (nidx == W_LEN) begin
				word_w = PROD_LEN_BYTES; // R1
			end else if (nidx <= PROD_LAST) begin
				word_w = prod_r[prod_off[3:0]]; // R2 R3 R4 R5 R6
			end
		end else begin
			if (nidx == W_TAG) begin
				word_w = CONG_TAG; // R7
			end else if (nidx == W_LEN) begin
				word_w = CONG_LEN_BYTES; // R8
			end else if (nidx == CW_MASK) begin
				word_w = mask_word; // R9
			end else if (nidx <= CONG_LAST) begin
				word_w = cong_w[cong_off[3:0]]; // R10
			end
		end
	end

	ocd_emit u_emit (
		.clk      (CLK),
		.rst_n    (RESET_N),
		.start    (DESC_START),
		.last_idx (last_idx),
		.ready    (DESC_READY),
		.valid    (DESC_VALID),
		.last     (DESC_LAST),
		.busy     (busy),
		.adv      (adv),
		.nidx     (nidx),
		.idx      (cur_idx)
	);

	// Counter words are captured when loaded, so a word held under
	// back-pressure does not change while the sink stalls.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			sel_r  <= OCD_SEL_PROD;
			data_r <= RST_WORD;
		end else begin
			if (!busy && DESC_START) begin
				sel_r <= DESC_SEL;
			end
			if (adv) begin
				data_r <= word_w;
			end
		end
	end

	assign DESC_DATA = data_r;
	assign DESC_BUSY = busy;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	a_prod_header: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && sel_r == OCD_SEL_PROD && cur_idx <= W_LEN) |-> // R1
		DESC_DATA == ((cur_idx == W_TAG) ? PROD_TAG : PROD_LEN_BYTES))
		else $error("product header word wrong");

	a_vendor_name: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_START && !busy && DESC_SEL == OCD_SEL_PROD && !WR) // R2
		##1 (DESC_READY && !WR) [*2] |=>
		DESC_DATA == prod_r[0])
		else $error("vendor name not in word 2");

	a_part_serial: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && sel_r == OCD_SEL_PROD && !$past(WR) // R3 R4
		&& (cur_idx == PW_PART || cur_idx == PW_SERIAL)) |->
		DESC_DATA == prod_r[4'(cur_idx - PW_VNAME)])
		else $error("part or serial word misplaced");

	a_rev_date: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && sel_r == OCD_SEL_PROD && !$past(WR) // R5 R6
		&& (cur_idx == PW_REV || cur_idx == PW_DATE)) |->
		DESC_DATA == prod_r[4'(cur_idx - PW_VNAME)])
		else $error("revision or date word misplaced");

	a_prod_length: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && DESC_LAST && sel_r == OCD_SEL_PROD) |-> // R1
		cur_idx == PROD_LAST)
		else $error("product descriptor length wrong");

	a_cong_header: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && sel_r == OCD_SEL_CONG && cur_idx <= W_LEN) |-> // R7
		DESC_DATA == ((cur_idx == W_TAG) ? CONG_TAG : CONG_LEN_BYTES))
		else $error("congestion header word wrong");

	a_cong_length: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && DESC_LAST && sel_r == OCD_SEL_CONG) |-> // R8
		cur_idx == CONG_LAST)
		else $error("congestion descriptor length wrong");

	a_mask_reserved: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && sel_r == OCD_SEL_CONG && cur_idx == CW_MASK) |-> // R19
		DESC_DATA[30:13] == 18'h0_0000)
		else $error("reserved mask bits not zero");

	a_mask_word: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && sel_r == OCD_SEL_CONG && cur_idx == CW_MASK // R9
		&& !$past(WR)) |->
		{DESC_DATA[31], DESC_DATA[12:0]} == // R11 R12 R13 R14 R16 R18
		{mask_cfg_r[31], mask_cfg_r[12:0]})
		else $error("validity mask word wrong");

	a_cred_interval: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && sel_r == OCD_SEL_CONG && cur_idx == 5'h07 // R10
		&& !$past(WR)) |-> DESC_DATA == cred_int_r)
		else $error("credit interval not in word 7");

	a_tx_transition: assert property (@(posedge CLK) disable iff (!RESET_N)
		($rose(TX_CREDIT_ZERO) && tx_zero_d_r == 1'b0) |=> // R21
		cnt[CI_TX_TRANS] == $past(cnt[CI_TX_TRANS]) + 32'h0000_0001)
		else $error("tx zero transition not counted");

	a_hold_stall: assert property (@(posedge CLK) disable iff (!RESET_N)
		(DESC_VALID && !DESC_READY) |=>
		(DESC_VALID && $stable(DESC_DATA) && $stable(cur_idx)))
		else $error("word changed under back-pressure");
endmodule
`default_nettype wire

//--- verilog/ocd_pkg.sv
// Constants and types shared by the descriptor framer and its helpers.
`default_nettype none
package ocd_pkg;
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 32;
	localparam int          IDX_W          = 5;
	localparam logic [31:0] PROD_TAG       = 32'h0001_0008;
	localparam logic [31:0] PROD_LEN_BYTES = 32'h0000_003c;
	localparam logic [31:0] CONG_TAG       = 32'h0001_0009;
	localparam logic [31:0] CONG_LEN_BYTES = 32'h0000_0038;
	localparam logic [4:0]  W_TAG          = 5'h00;
	localparam logic [4:0]  W_LEN          = 5'h01;
	localparam logic [4:0]  PW_VNAME       = 5'h02;
	localparam logic [4:0]  PW_PART        = 5'h06;
	localparam logic [4:0]  PW_SERIAL      = 5'h0a;
	localparam logic [4:0]  PW_REV         = 5'h0e;
	localparam logic [4:0]  PW_DATE        = 5'h10;
	localparam logic [4:0]  PROD_LAST      = 5'h10;
	localparam logic [4:0]  CW_MASK        = 5'h02;
	localparam logic [4:0]  CW_FIRST       = 5'h03;
	localparam logic [4:0]  CONG_LAST      = 5'h0f;
	localparam int          PROD_WORDS     = 15;
	localparam int          NUM_CNT        = 11;
	localparam int          NUM_CW         = 13;
	localparam logic [7:0]  OFS_PROD       = 8'h00;
	localparam logic [7:0]  OFS_PROD_END   = 8'h3c;
	localparam logic [7:0]  OFS_MASK       = 8'h40;
	localparam logic [7:0]  OFS_CRED_INT   = 8'h44;
	localparam logic [7:0]  OFS_DISC_INT   = 8'h48;
	localparam logic [7:0]  OFS_CNT        = 8'h80;
	localparam logic [7:0]  OFS_CNT_END    = 8'hac;
	localparam logic [31:0] MASK_WMASK     = 32'h8000_1fff;
	localparam logic [31:0] RST_WORD       = 32'h0000_0000;
	localparam int          MB_SAMPLED     = 31;
	localparam int          MB_DISC_INT    = 6;
	localparam int          MB_DISC_CNT    = 5;
	localparam int          MB_CRED_INT    = 4;
	localparam logic [3:0]  CI_TX_TRANS    = 4'h0;
	localparam logic [3:0]  CI_RX_TRANS    = 4'h1;
	typedef enum logic {
		OCD_SEL_PROD,
		OCD_SEL_CONG
	} ocd_sel_t;
endpackage
`default_nettype wire

//--- verilog/ocd_counter.sv
// Free running 32-bit event counter that wraps to zero on overflow.
`timescale 1ns/1ns
`default_nettype none
module ocd_counter
	import ocd_pkg::*;
(
	input  wire logic              clk,   // System clock.
	input  wire logic              rst_n, // Synchronous reset, active low.
	input  wire logic              inc,   // Count one event.
	output logic [DATA_W-1:0]      count  // Current count.
);
	logic [DATA_W-1:0] count_r;
	logic [DATA_W-1:0] count_nxt;

	// Plain modular add; software has no way to clear it.
	assign count_nxt = inc ? count_r + 32'h0000_0001 : count_r; // R20
	assign count     = count_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_r <= RST_WORD;
		end else begin
			count_r <= count_nxt;
		end
	end

	a_count_wrap: assert property (@(posedge clk) disable iff (!rst_n) // R20
		(inc && count_r == 32'hffff_ffff) |=> count_r == 32'h0000_0000)
		else $error("counter did not wrap to zero");

	a_count_step: assert property (@(posedge clk) disable iff (!rst_n) // R20
		inc |=> count_r == $past(count_r) + 32'h0000_0001)
		else $error("counter missed an event");
endmodule
`default_nettype wire

//--- verilog/ocd_emit.sv
// Word sequencer that walks one descriptor under sink back-pressure.
`timescale 1ns/1ns
`default_nettype none
module ocd_emit
	import ocd_pkg::*;
(
	input  wire logic              clk,      // System clock.
	input  wire logic              rst_n,    // Synchronous reset, low.
	input  wire logic              start,    // Begin a descriptor.
	input  wire logic [IDX_W-1:0]  last_idx, // Index of final word.
	input  wire logic              ready,    // Sink takes the word.
	output logic                   valid,    // Word on offer.
	output logic                   last,     // Offered word is final.
	output logic                   busy,     // Descriptor in flight.
	output logic                   adv,      // Load the next word.
	output logic [IDX_W-1:0]       nidx,     // Index of word to load.
	output logic [IDX_W-1:0]       idx       // Index of offered word.
);
	typedef enum logic {
		ST_IDLE,
		ST_SEND
	} ocd_emit_st_t;

	ocd_emit_st_t     state_r;
	ocd_emit_st_t     state_nxt;
	logic [IDX_W-1:0] idx_r;
	logic [IDX_W-1:0] len_r;
	logic             take;

	assign busy  = (state_r == ST_SEND);
	assign valid = busy;
	assign last  = busy && (idx_r == len_r);
	assign take  = valid && ready;
	assign adv   = (!busy && start) || (take && !last);
	assign nidx  = busy ? idx_r + 5'h01 : W_TAG;
	assign idx   = idx_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (start) begin
					state_nxt = ST_SEND;
				end
			end
			ST_SEND: begin
				if (take && last) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			idx_r   <= W_TAG;
			len_r   <= W_TAG;
		end else begin
			state_r <= state_nxt;
			if (adv) begin
				idx_r <= nidx;
			end
			if (!busy && start) begin
				len_r <= last_idx;
			end
		end
	end
endmodule
`default_nettype wire

//--- test/ocd_sink.sv
// Model of the requesting port that takes descriptor words off the stream.
`timescale 1ns/1ns
`default_nettype none
module ocd_sink (
	input  wire logic        clk,     // System clock.
	input  wire logic        rst_n,   // Synchronous reset, active low.
	input  wire logic        valid,   // Word on offer.
	input  wire logic [31:0] data,    // Offered word.
	input  wire logic        last,    // Offered word is final.
	input  wire logic        slow,    // Stall every other cycle.
	input  wire logic        clr,     // Forget the stored descriptor.
	output var  logic        ready,   // Word is taken.
	output var  logic [5:0]  n,       // Words taken so far.
	output var  logic [5:0]  last_at, // Index of the final word.
	output logic             disc_ok, // Discard count usable.
	output logic             zc_ok    // Tx zero credit count usable.
);
	logic [31:0] words [0:31];

	////////////////////////////////////////////////////////////////////////
	// A slow receiver toggles ready, so every word after the first sees a stall.
	always_ff @(posedge clk) begin
		ready <= !rst_n ? 1'b1 : (slow ? ~ready : 1'b1);
		if (!rst_n || clr) begin
			n       <= 6'h00;
			last_at <= 6'h3f;
		end else if (valid && ready) begin
			words[n[4:0]] <= data;
			n             <= n + 6'h01;
			if (last) begin
				last_at <= n;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The receiver trusts these counts only with their companion bits.
	assign disc_ok = words[2][5] & words[2][6];
	assign zc_ok   = words[2][2] & words[2][4];
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the descriptor framer.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import ocd_pkg::*;
	typedef struct {
		logic [7:0]  a;
		logic [31:0] w;
		logic [31:0] e;
	} ocd_row_t;
	logic        CLK, RESET_N, WR, RD, DESC_START, DESC_READY, DESC_VALID;
	logic        DESC_LAST, DESC_BUSY, slow, clr;
	logic [7:0]  ADDR;
	logic [31:0] WDATA, RDATA, DESC_DATA, d;
	logic [10:0] ev;
	logic [5:0]  n, last_at;
	ocd_sel_t    DESC_SEL;
	int          err_count, check_count, i, k;
	ocd_row_t    rows [8];

	ocd_framer uut (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.TX_CREDIT_ZERO(ev[0]), .RX_CREDIT_ZERO(ev[1]),
		.TX_ZC_HIT(ev[2]), .RX_ZC_HIT(ev[3]), .TX_DISCARD(ev[4]),
		.TX_LR(ev[5]), .RX_LR(ev[6]), .VENDOR_EVT(ev[10:7]),
		.DESC_START(DESC_START), .DESC_SEL(DESC_SEL),
		.DESC_READY(DESC_READY), .DESC_VALID(DESC_VALID),
		.DESC_DATA(DESC_DATA), .DESC_LAST(DESC_LAST),
		.DESC_BUSY(DESC_BUSY));
	ocd_sink sink (.clk(CLK), .rst_n(RESET_N), .valid(DESC_VALID),
		.data(DESC_DATA), .last(DESC_LAST), .slow(slow), .clr(clr),
		.ready(DESC_READY), .n(n), .last_at(last_at), .disc_ok(),
		.zc_ok());

	always #2 CLK = ~CLK;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] pv(input int j);
		return 32'h4161_3020 + j * 32'h0101_0100;
	endfunction
	// Counter k is 3 rises, 6 rises, then k+1 pulses for the rest.
	function automatic logic [31:0] ec(input int j);
		return (j == 0) ? 32'h3 : (j == 1) ? 32'h6 : j + 1;
	endfunction
	function automatic logic [31:0] ew(input ocd_sel_t s, input int j);
		if (j == 0) return (s == OCD_SEL_PROD) ? 32'h0001_0008 : 32'h0001_0009;
		if (j == 1) return (s == OCD_SEL_PROD) ? 32'h0000_003c : 32'h0000_0038;
		if (s == OCD_SEL_PROD) return pv(j - 2);
		if (j == 2) return 32'h8000_00a5;
		if (j < 7) return ec(j - 3);
		if (j == 7) return 32'h0000_0064;
		if (j == 8) return ec(4);
		if (j == 9) return 32'h0000_01f4;
		return ec(j - 5);
	endfunction

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk32(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge CLK);
		WR    <= 1'b1;
		ADDR  <= a;
		WDATA <= w;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge CLK);
		RD   <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		#1 q = RDATA;
	endtask
	// A second start while busy must be dropped without trace.
	task automatic desc(input ocd_sel_t s, input logic slw, again);
		int j;
		@(posedge CLK);
		clr  <= 1'b1;
		slow <= slw;
		@(posedge CLK);
		clr        <= 1'b0;
		DESC_START <= 1'b1;
		DESC_SEL   <= s;
		@(posedge CLK);
		DESC_START <= 1'b0;
		if (again) begin
			@(posedge CLK);
			DESC_START <= 1'b1;
			DESC_SEL   <= OCD_SEL_PROD;
			@(posedge CLK);
			DESC_START <= 1'b0;
		end
		for (j = 0; j < 200; j++) begin
			@(posedge CLK);
			#1;
			if (last_at != 6'h3f) break;
		end
		if (j == 200) begin
			err_count++;
			print_verdict();
		end
		chk1("busy after last", 1'b0, DESC_BUSY);
		for (j = 0; j < 17; j++) begin
			if (s == OCD_SEL_CONG && j == 16) break;
			chk32("word", ew(s, j), sink.words[j]);
		end
		chk32("last index", (s == OCD_SEL_PROD) ? 16 : 15, 32'(last_at));
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		CLK = 0; RESET_N = 0; WR = 0; RD = 0; ADDR = 0; WDATA = 0;
		DESC_START = 0; DESC_SEL = OCD_SEL_PROD; slow = 0; clr = 0; ev = 0;
		err_count = 0; check_count = 0;
		rows[0] = '{8'h40, 32'h7fff_ffff, 32'h0000_1fff};
		rows[1] = '{8'h44, 32'h0000_0064, 32'h0000_0064};
		rows[2] = '{8'h48, 32'h0000_01f4, 32'h0000_01f4};
		rows[3] = '{8'h50, 32'hdead_beef, 32'h0000_0000};
		rows[4] = '{8'h41, 32'h1234_5678, 32'h0000_0000};
		rows[5] = '{8'h80, 32'h5555_5555, 32'h0000_0000};
		rows[6] = '{8'h3c, 32'h0bad_0bad, 32'h0000_0000};
		rows[7] = '{8'h40, 32'h8000_e0a5, 32'h8000_00a5};
		repeat (3) @(posedge CLK);
		RESET_N <= 1'b1;
		for (i = 0; i < 15; i++) wr(8'(i * 4), pv(i));
		foreach (rows[r]) begin
			wr(rows[r].a, rows[r].w);
			rd(rows[r].a, d);
			chk32("register", rows[r].e, d);
		end
		rd(8'h10, d);
		chk32("part word", pv(4), d);
		@(posedge CLK);
		#1 chk32("idle read data", 32'h0, RDATA);
		desc(OCD_SEL_PROD, 1'b0, 1'b0);
		// Credit level held two cycles must count once.
		for (i = 0; i < 12; i++) begin
			@(posedge CLK);
			ev[0] <= (i % 4) < 2;
			ev[1] <= (i % 2) == 0;
			for (k = 2; k < 11; k++) ev[k] <= i < k + 1;
		end
		@(posedge CLK);
		ev <= 11'h0;
		for (k = 0; k < 11; k++) begin
			rd(8'(8'h80 + 4 * k), d);
			chk32("counter", ec(k), d);
		end
		wr(8'h84, 32'h0);
		rd(8'h84, d);
		chk32("counter kept", ec(1), d);
		desc(OCD_SEL_CONG, 1'b1, 1'b1);
		chk1("discard usable", 1'b0, sink.disc_ok);
		chk1("zero credit usable", 1'b0, sink.zc_ok);
		@(posedge CLK);
		RESET_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RESET_N <= 1'b1;
		rd(8'h80, d);
		chk32("counter after reset", 32'h0, d);
		chk1("valid after reset", 1'b0, DESC_VALID);
		print_verdict();
	end
endmodule
`default_nettype wire
